/* File: include/gpio_port_pkg.sv */
// Package: register map, field layout and reset values of the GPIO port
package gpio_port_pkg;

    // ======================================================================
    // Geometry
    // ======================================================================
    localparam int unsigned PINS   = 8;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned IDX_W  = 8;

    // ======================================================================
    // Register indices (byte address is four times the index)
    // ======================================================================
    localparam logic [7:0] IDX_DIRECTION      = 8'h00;
    localparam logic [7:0] IDX_DIRECTION_SET  = 8'h01;
    localparam logic [7:0] IDX_DIRECTION_CLR  = 8'h02;
    localparam logic [7:0] IDX_DIRECTION_TGL  = 8'h03;
    localparam logic [7:0] IDX_OUTPUT_LEVEL   = 8'h04;
    localparam logic [7:0] IDX_OUTPUT_SET     = 8'h05;
    localparam logic [7:0] IDX_OUTPUT_CLR     = 8'h06;
    localparam logic [7:0] IDX_OUTPUT_TOGGLE  = 8'h07;
    localparam logic [7:0] IDX_INPUT_VALUE    = 8'h08;
    localparam logic [7:0] IDX_PIN_FLAGS      = 8'h09;
    localparam logic [7:0] IDX_PORT_SLEW      = 8'h0a;
    localparam logic [7:0] IDX_PIN_CONFIG     = 8'h10;
    localparam logic [7:0] IDX_FLAG_MASK      = 8'h18;
    localparam logic [7:0] IDX_ALIAS_BASE     = 8'h20;
    localparam logic [7:0] IDX_ALIAS_DIR      = 8'h20;
    localparam logic [7:0] IDX_ALIAS_OUT      = 8'h21;
    localparam logic [7:0] IDX_ALIAS_INPUT    = 8'h22;
    localparam logic [7:0] IDX_ALIAS_FLAGS    = 8'h23;

    // ======================================================================
    // Field positions and reset values
    // ======================================================================
    localparam int unsigned SLEW_LIMIT_BIT    = 0;
    localparam logic [7:0]  PIN_CONFIG_WMASK  = 8'h8f;
    localparam logic [7:0]  RESET_BYTE        = 8'h00;
    localparam logic [7:0]  FLAG_MASK_RESET   = 8'hff;

    // Input/sense selector encodings
    localparam logic [2:0] SENSE_OFF_BUFFER_ON = 3'h0;
    localparam logic [2:0] SENSE_ANY_EDGE      = 3'h1;
    localparam logic [2:0] SENSE_RISING        = 3'h2;
    localparam logic [2:0] SENSE_FALLING       = 3'h3;
    localparam logic [2:0] SENSE_BUFFER_OFF    = 3'h4;
    localparam logic [2:0] SENSE_LOW_LEVEL     = 3'h5;

    // Per-pin configuration byte
    typedef struct packed {
        logic       invert_enable;
        logic [2:0] reserved;
        logic       weak_pull_enable;
        logic [2:0] input_sense_select;
    } pin_cfg_t;

    // Pad-side signals of one port, driven toward the pads
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] drive_enable;
        logic [7:0] pull_enable;
        logic [7:0] input_buffer_enable;
        logic       slew_limit_enable;
    } pad_ctrl_t;

endpackage : gpio_port_pkg

/* File: hw/gpio_port_toggle_sense_regs.sv */
// Module: APB register slave and pin logic of an eight-pin GPIO port
//
// Contract
// RULE1: writing one to toggle or input-value register flips the output bit
// RULE2: reading the toggle register returns the output-level register
// RULE3: with input buffer on, input-value bit follows the pin level
// RULE4: with input buffer off, input-value bit holds its old value
// RULE5: a pin flag sets when pin activity matches its sense selector
// RULE6: writing one clears a flag; writing zero changes nothing
// RULE7: port slew bit zero enables slew limiting on all pins
// RULE8: pin config bit seven inverts both input and output value
// RULE9: pin config bit three enables pull-up only for input-only pins
// RULE10: sense codes one, two, three select both, rising, falling edges
// RULE11: code zero disables interrupt; code four also disables buffer
// RULE12: code five senses low level; codes above five are reserved
// RULE13: alias map mirrors direction, output, input, flags with same effects
// RULE14: output level reaches the pin only while its direction bit is set
// RULE15: one interrupt request stays high while any flag is set; code raises irq only for set flags whose flag_mask_q bit is set
// RULE16: pins pass a two-flop synchroniser before any logic reads them
`timescale 1ns/1ps

module gpio_port_toggle_sense_regs (
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    input  wire logic                             clk_en,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [gpio_port_pkg::ADDR_W-1:0] paddr,
    input  wire logic [gpio_port_pkg::DATA_W-1:0] pwdata,
    input  wire logic [3:0]                       pstrb,
    output logic      [gpio_port_pkg::DATA_W-1:0] prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    input  wire logic [7:0]                       pin_level_in,
    output gpio_port_pkg::pad_ctrl_t              pad_ctrl,
    output logic                                  irq
);

    // ======================================================================
    // Register state
    // ======================================================================
    logic [7:0]              direction_q;
    logic [7:0]              direction_d;
    logic [7:0]              output_level_q;
    logic [7:0]              output_level_d;
    logic [7:0]              input_value_q;
    logic [7:0]              pin_flags_q;
    logic [7:0]              pin_flags_d;
    logic [7:0]              flag_mask_q;
    logic                    slew_limit_q;
    gpio_port_pkg::pin_cfg_t pin_cfg_q [8];

    // Synchroniser stages
    logic [7:0] pin_meta_q;
    logic [7:0] pin_sync_q;

    // Bus state
    logic                    answer_q;
    logic [31:0]             rdata_q;
    logic                    err_q;
    logic [7:0]              reg_idx;
    logic                    addr_ok;
    logic                    mapped;
    logic [31:0]             rdata_d;
    logic                    wr_fire;
    logic [7:0]              wbyte;

    // Pin-side combinational terms
    logic [7:0] buf_en;
    logic [7:0] sample;
    logic [7:0] sense_hit;
    logic [7:0] flag_clear;
    logic       cfg_write;
    logic [2:0] cfg_sel;

    // ======================================================================
    // Address decode
    // ======================================================================
    // Only word-aligned addresses inside the low index window decode
    assign reg_idx = paddr[9:2];
    assign addr_ok = (paddr[1:0] == 2'b00)
                   && (paddr[gpio_port_pkg::ADDR_W-1:10] == '0);
    assign wbyte   = pwdata[7:0];
    assign cfg_sel = reg_idx[2:0];

    // Which indices answer without error
    always_comb begin
        mapped = 1'b0;
        if (addr_ok) begin
            if (reg_idx <= gpio_port_pkg::IDX_PORT_SLEW) begin
                mapped = 1'b1;
            end else if ((reg_idx & 8'hf8)
                         == gpio_port_pkg::IDX_PIN_CONFIG) begin
                mapped = 1'b1;
            end else if (reg_idx == gpio_port_pkg::IDX_FLAG_MASK) begin
                mapped = 1'b1;
            end else if ((reg_idx & 8'hfc)
                         == gpio_port_pkg::IDX_ALIAS_BASE) begin
                mapped = 1'b1;
            end
        end
    end

    // ======================================================================
    // APB handshake
    // ======================================================================
    // One wait state: read data is captured into a flop in the first
    // access cycle so prdata never comes straight from the decode cone.
    assign pready  = answer_q;
    assign pslverr = err_q & answer_q;
    assign prdata  = rdata_q;

    // Write strobe: only at the edge where the master sees pready high
    assign wr_fire = psel & penable & pwrite & answer_q & clk_en
                   & mapped & pstrb[0];

    // Answer flag rises one cycle into the access phase, drops after
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            answer_q <= 1'b0;
            err_q    <= 1'b0;
        end else if (clk_en) begin
            answer_q <= psel & penable & ~answer_q;
            err_q    <= psel & penable & ~answer_q & ~mapped;
        end
    end

    // ======================================================================
    // Read multiplexer
    // ======================================================================
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (mapped && !pwrite) begin
            if ((reg_idx & 8'hf8) == gpio_port_pkg::IDX_PIN_CONFIG) begin
                rdata_d[7:0] = pin_cfg_q[cfg_sel];
            end else begin
                unique case (reg_idx)
                    gpio_port_pkg::IDX_DIRECTION,
                    gpio_port_pkg::IDX_DIRECTION_SET,
                    gpio_port_pkg::IDX_DIRECTION_CLR,
                    gpio_port_pkg::IDX_DIRECTION_TGL,
                    gpio_port_pkg::IDX_ALIAS_DIR:
                        rdata_d[7:0] = direction_q;
                    // RULE2: toggle reads output
                    gpio_port_pkg::IDX_OUTPUT_LEVEL,
                    gpio_port_pkg::IDX_OUTPUT_SET,
                    gpio_port_pkg::IDX_OUTPUT_CLR,
                    gpio_port_pkg::IDX_OUTPUT_TOGGLE,
                    gpio_port_pkg::IDX_ALIAS_OUT:
                        rdata_d[7:0] = output_level_q;
                    gpio_port_pkg::IDX_INPUT_VALUE,
                    gpio_port_pkg::IDX_ALIAS_INPUT:
                        rdata_d[7:0] = input_value_q;
                    gpio_port_pkg::IDX_PIN_FLAGS,
                    gpio_port_pkg::IDX_ALIAS_FLAGS:
                        rdata_d[7:0] = pin_flags_q;
                    gpio_port_pkg::IDX_PORT_SLEW:
                        rdata_d[gpio_port_pkg::SLEW_LIMIT_BIT] = slew_limit_q;
                    gpio_port_pkg::IDX_FLAG_MASK:
                        rdata_d[7:0] = flag_mask_q;
                    default:
                        rdata_d = 32'h0000_0000;
                endcase
            end
        end
    end

    // Capture read data once, hold it through the answer cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (clk_en && psel && penable && !answer_q) begin
            rdata_q <= rdata_d;
        end
    end

    // ======================================================================
    // Direction register
    // ======================================================================
    // Set, clear and toggle views avoid read-modify-write in software
    always_comb begin
        direction_d = direction_q;
        if (wr_fire) begin
            unique case (reg_idx)
                gpio_port_pkg::IDX_DIRECTION,
                // RULE13: alias direction write
                gpio_port_pkg::IDX_ALIAS_DIR:
                    direction_d = wbyte;
                gpio_port_pkg::IDX_DIRECTION_SET:
                    direction_d = direction_q | wbyte;
                gpio_port_pkg::IDX_DIRECTION_CLR:
                    direction_d = direction_q & ~wbyte;
                gpio_port_pkg::IDX_DIRECTION_TGL:
                    direction_d = direction_q ^ wbyte;
                default:
                    direction_d = direction_q;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            direction_q <= gpio_port_pkg::RESET_BYTE;
        end else if (clk_en) begin
            direction_q <= direction_d;
        end
    end

    // ======================================================================
    // Output-level register
    // ======================================================================
    always_comb begin
        output_level_d = output_level_q;
        if (wr_fire) begin
            unique case (reg_idx)
                gpio_port_pkg::IDX_OUTPUT_LEVEL,
                // RULE13: alias output write
                gpio_port_pkg::IDX_ALIAS_OUT:
                    output_level_d = wbyte;
                gpio_port_pkg::IDX_OUTPUT_SET:
                    output_level_d = output_level_q | wbyte;
                gpio_port_pkg::IDX_OUTPUT_CLR:
                    output_level_d = output_level_q & ~wbyte;
                // RULE1: ones toggle outputs
                gpio_port_pkg::IDX_OUTPUT_TOGGLE,
                gpio_port_pkg::IDX_INPUT_VALUE,
                gpio_port_pkg::IDX_ALIAS_INPUT:
                    output_level_d = output_level_q ^ wbyte;
                default:
                    output_level_d = output_level_q;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_level_q <= gpio_port_pkg::RESET_BYTE;
        end else if (clk_en) begin
            output_level_q <= output_level_d;
        end
    end

    // ======================================================================
    // Port slew control and interrupt mask
    // ======================================================================
    // Mask resets open so a set flag raises irq without any setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slew_limit_q <= 1'b0;
            flag_mask_q  <= gpio_port_pkg::FLAG_MASK_RESET;
        end else if (clk_en && wr_fire) begin
            if (reg_idx == gpio_port_pkg::IDX_PORT_SLEW) begin
                slew_limit_q <= wbyte[gpio_port_pkg::SLEW_LIMIT_BIT];
            end
            if (reg_idx == gpio_port_pkg::IDX_FLAG_MASK) begin
                flag_mask_q <= wbyte;
            end
        end
    end

    // ======================================================================
    // Pin configuration bytes
    // ======================================================================
    // Reserved bits 6:4 are never stored and read back as zero
    assign cfg_write = wr_fire
        && ((reg_idx & 8'hf8) == gpio_port_pkg::IDX_PIN_CONFIG);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++) begin
                pin_cfg_q[i] <= gpio_port_pkg::RESET_BYTE;
            end
        end else if (clk_en && cfg_write) begin
            pin_cfg_q[cfg_sel] <= wbyte & gpio_port_pkg::PIN_CONFIG_WMASK;
        end
    end

    // ======================================================================
    // Input synchroniser
    // ======================================================================
    // RULE16: two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_q <= gpio_port_pkg::RESET_BYTE;
            pin_sync_q <= gpio_port_pkg::RESET_BYTE;
        end else if (clk_en) begin
            pin_meta_q <= pin_level_in;
            pin_sync_q <= pin_meta_q;
        end
    end

    // ======================================================================
    // Per-pin sense logic
    // ======================================================================
    // The previous sample is the input-value bit itself, so an edge is a
    // difference between the fresh sample and what software last could see.
    // Flipping the invert bit on a live pin therefore looks like an edge.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            // RULE11: code four kills buffer
            buf_en[i] = pin_cfg_q[i].input_sense_select
                        != gpio_port_pkg::SENSE_BUFFER_OFF;
            // RULE8: input inversion
            sample[i] = pin_sync_q[i] ^ pin_cfg_q[i].invert_enable;
            sense_hit[i] = 1'b0;
            if (buf_en[i]) begin
                unique case (pin_cfg_q[i].input_sense_select)
                    // RULE10: edge sense codes
                    gpio_port_pkg::SENSE_ANY_EDGE:
                        sense_hit[i] = sample[i] ^ input_value_q[i];
                    gpio_port_pkg::SENSE_RISING:
                        sense_hit[i] = sample[i] & ~input_value_q[i];
                    gpio_port_pkg::SENSE_FALLING:
                        sense_hit[i] = ~sample[i] & input_value_q[i];
                    // RULE12: low level sense
                    gpio_port_pkg::SENSE_LOW_LEVEL:
                        sense_hit[i] = ~sample[i];
                    // RULE11: code zero no interrupt
                    default:
                        sense_hit[i] = 1'b0;
                endcase
            end
        end
    end

    // ======================================================================
    // Input-value register
    // ======================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_value_q <= gpio_port_pkg::RESET_BYTE;
        end else if (clk_en) begin
            for (int i = 0; i < 8; i++) begin
                // RULE3: follow pin when buffered
                if (buf_en[i]) begin
                    input_value_q[i] <= sample[i];
                end
                // RULE4: hold when buffer off
            end
        end
    end

    // ======================================================================
    // Pin event flags
    // ======================================================================
    // RULE6: write one clears
    assign flag_clear = (wr_fire
        && (reg_idx == gpio_port_pkg::IDX_PIN_FLAGS
            || reg_idx == gpio_port_pkg::IDX_ALIAS_FLAGS)) ? wbyte : 8'h00;

    // RULE5: set on match, set beats clear
    assign pin_flags_d = sense_hit | (pin_flags_q & ~flag_clear);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_flags_q <= gpio_port_pkg::RESET_BYTE;
        end else if (clk_en) begin
            pin_flags_q <= pin_flags_d;
        end
    end

    // ======================================================================
    // Interrupt output
    // ======================================================================
    // RULE15: level request from flags
    assign irq = |(pin_flags_q & flag_mask_q);

    // ======================================================================
    // Pad controls
    // ======================================================================
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            // RULE8: output inversion
            pad_ctrl.level[i] = output_level_q[i]
                              ^ pin_cfg_q[i].invert_enable;
            // RULE9: pull only when input-only
            pad_ctrl.pull_enable[i] = pin_cfg_q[i].weak_pull_enable
                                    & ~direction_q[i];
        end
        // RULE14: drive only with direction set
        pad_ctrl.drive_enable        = direction_q;
        pad_ctrl.input_buffer_enable = buf_en;
        // RULE7: port-wide slew limit
        pad_ctrl.slew_limit_enable   = slew_limit_q;
    end

endmodule : gpio_port_toggle_sense_regs

/* File: tb/gpio_port_chk.sv */
// Checker: bus timing and pad control properties of the port
`timescale 1ns/1ps
module gpio_port_chk (
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic                     pready,
    input wire gpio_port_pkg::pad_ctrl_t pad_ctrl,
    input wire logic                     irq
);
    // ==========
    // Bus phases
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_done;
    // A write lands only at the answer edge
    assign wr_done = psel && penable && pwrite && pready;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    // ==========
    // Properties
    a_one_wait:
        assert property (s_setup ##1 s_wait |=> pready)
        else $error("answer not after one wait state");
    a_ready_pulse:
        assert property (pready |=> !pready)
        else $error("ready held for more than one cycle");
    a_pull_input_only:
        assert property ((pad_ctrl.pull_enable & pad_ctrl.drive_enable)
                         == 8'h00)
        else $error("pull-up on while pin drives");
    a_slew_by_write:
        assert property ($changed(pad_ctrl.slew_limit_enable)
                         |-> $past(wr_done))
        else $error("slew control moved without a write");
    a_level_by_write:
        assert property ($changed(pad_ctrl.level) |-> $past(wr_done))
        else $error("pad level moved without a write");
    a_drive_by_write:
        assert property ($changed(pad_ctrl.drive_enable) |-> $past(wr_done))
        else $error("drive enable moved without a write");
    a_buffer_by_write:
        assert property ($changed(pad_ctrl.input_buffer_enable)
                         |-> $past(wr_done))
        else $error("input buffer moved without a write");
    a_irq_clear_write:
        assert property ($fell(irq) |-> $past(wr_done) || $past(wr_done, 2))
        else $error("interrupt dropped without a write");
endmodule : gpio_port_chk

bind gpio_port_toggle_sense_regs gpio_port_chk chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .pad_ctrl(pad_ctrl), .irq(irq)
);

/* File: tb/pad_model.sv */
// Board model: resolves each pad from port drive, board drive and pull-up
`timescale 1ns/1ps
module pad_model (
    input  wire logic                     pclk,
    input  wire gpio_port_pkg::pad_ctrl_t pad_ctrl,
    input  wire logic [7:0]               board_lvl,
    input  wire logic [7:0]               board_drv,
    output logic      [7:0]               pin_level_in
);
    // ==========
    // Pad resolution
    logic [7:0] float_q = 8'h55;
    // Undriven pads without pull-up wander so no test leans on a stale level
    always_ff @(posedge pclk) begin
        float_q <= ~float_q;
    end
    assign pin_level_in =
        (pad_ctrl.drive_enable & pad_ctrl.level) |
        (~pad_ctrl.drive_enable & board_drv & board_lvl) |
        (~pad_ctrl.drive_enable & ~board_drv &
         (pad_ctrl.pull_enable | float_q));
endmodule : pad_model

/* File: tb/testbench.sv */
// Testbench: register and pin scenarios of the GPIO port over APB
`timescale 1ns/1ps
module testbench;
    // ==========
    // Signals
    logic                      pclk = 1'b0;
    logic                      presetn = 1'b0;
    logic                      psel = 1'b0;
    logic                      penable = 1'b0;
    logic                      pwrite = 1'b0;
    logic [11:0]               paddr = 12'h000;
    logic [31:0]               pwdata = 32'h0;
    logic [7:0]                board_lvl = 8'h0a;
    logic [7:0]                board_drv = 8'hff;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic                      irq;
    logic [7:0]                pins;
    gpio_port_pkg::pad_ctrl_t  pad_ctrl;
    logic [31:0]               rd;
    logic                      er;
    logic                      fall;
    int                        err_count = 0;
    int                        checks = 0;
    // Half period of 12.5 ns gives 40 MHz
    always #12.5 pclk = ~pclk;
    gpio_port_toggle_sense_regs dut_u (
        .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_level_in(pins), .pad_ctrl(pad_ctrl),
        .irq(irq));
    pad_model pad_u (.pclk(pclk), .pad_ctrl(pad_ctrl),
        .board_lvl(board_lvl), .board_drv(board_drv), .pin_level_in(pins));
    // ==========
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    // One idle edge first so psel is never driven twice in one step
    task automatic apb(input logic w, input logic [7:0] i,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, i, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (n >= 20) chk(32'h0, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rc(input logic [7:0] i, input logic [31:0] exp);
        apb(1'b0, i, 32'h0);
        chk(rd, exp);
    endtask : rc
    task automatic close_out();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out
    // ==========
    // Scenarios
    initial begin
        tick(4);
        presetn <= 1'b1;
        rc(gpio_port_pkg::IDX_PIN_FLAGS, 32'h0);
        rc(gpio_port_pkg::IDX_PORT_SLEW, 32'h0);
        rc(gpio_port_pkg::IDX_PIN_CONFIG, 32'h0);
        rc(gpio_port_pkg::IDX_FLAG_MASK, 32'hff);
        apb(1'b0, 8'h0b, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        apb(1'b1, gpio_port_pkg::IDX_OUTPUT_LEVEL, 32'h0f);
        apb(1'b1, gpio_port_pkg::IDX_OUTPUT_TOGGLE, 32'h3c);
        rc(gpio_port_pkg::IDX_OUTPUT_TOGGLE, 32'h33);
        apb(1'b1, gpio_port_pkg::IDX_INPUT_VALUE, 32'h01);
        apb(1'b1, gpio_port_pkg::IDX_OUTPUT_TOGGLE, 32'h00);
        rc(gpio_port_pkg::IDX_ALIAS_OUT, 32'h32);
        // Upper nibble driven by the port, lower nibble by the board
        apb(1'b1, gpio_port_pkg::IDX_ALIAS_DIR, 32'hf0);
        board_drv <= 8'h0f;
        tick(5);
        chk(32'(pad_ctrl.drive_enable), 32'hf0);
        rc(gpio_port_pkg::IDX_ALIAS_INPUT, 32'h3a);
        apb(1'b1, gpio_port_pkg::IDX_PIN_CONFIG, 32'h80);
        apb(1'b1, gpio_port_pkg::IDX_PIN_CONFIG + 8'h04, 32'h80);
        tick(5);
        chk(32'(pad_ctrl.level), 32'h23);
        rc(gpio_port_pkg::IDX_INPUT_VALUE, 32'h3b);
        apb(1'b1, gpio_port_pkg::IDX_PORT_SLEW, 32'hff);
        tick(1);
        chk(32'(pad_ctrl.slew_limit_enable), 32'h1);
        rc(gpio_port_pkg::IDX_PORT_SLEW, 32'h01);
        board_drv <= 8'h07;
        apb(1'b1, gpio_port_pkg::IDX_PIN_CONFIG + 8'h03, 32'h08);
        tick(1);
        chk(32'(pad_ctrl.pull_enable), 32'h08);
        apb(1'b1, gpio_port_pkg::IDX_DIRECTION, 32'hf8);
        tick(1);
        chk(32'(pad_ctrl.pull_enable), 32'h00);
        board_lvl[1] <= 1'b0;
        // Every sense code on pin 1: rise, clear, fall, mask
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, gpio_port_pkg::IDX_PIN_CONFIG + 8'h01, 32'(c));
            apb(1'b1, gpio_port_pkg::IDX_PIN_FLAGS, 32'hff);
            board_lvl[1] <= 1'b1;
            tick(5);
            chk(32'(pad_ctrl.input_buffer_enable[1]), 32'(c != 4));
            rc(gpio_port_pkg::IDX_PIN_FLAGS,
               32'(c inside {1, 2, 5}) << 1);
            apb(1'b0, gpio_port_pkg::IDX_INPUT_VALUE, 32'h0);
            chk(rd & 32'h2, (c == 4) ? 32'h0 : 32'h2);
            apb(1'b1, gpio_port_pkg::IDX_ALIAS_FLAGS, 32'hff);
            rc(gpio_port_pkg::IDX_PIN_FLAGS, 32'h0);
            board_lvl[1] <= 1'b0;
            fall = c inside {1, 3, 5};
            tick(5);
            apb(1'b1, gpio_port_pkg::IDX_PIN_FLAGS, 32'h00);
            rc(gpio_port_pkg::IDX_PIN_FLAGS,
               32'(fall) << 1);
            chk(32'(irq), 32'(fall));
            apb(1'b1, gpio_port_pkg::IDX_FLAG_MASK, 32'h00);
            tick(2);
            chk(32'(irq), 32'h0);
            apb(1'b1, gpio_port_pkg::IDX_FLAG_MASK, 32'hff);
        end
        close_out();
    end
    // Whole run is under two thousand cycles
    initial begin
        tick(20000);
        err_count++;
        close_out();
    end
endmodule : testbench
